// file: logic/pgc_regs.v
`timescale 1ns/1ps
`include "pgc_map.vh"
module pgc_regs (
   // Clock and reset
   input  wire        clk_in,
   input  wire        rst_n_in,
   input  wire        soft_rst_in,
   // AXI4-Lite write
   input  wire [7:0]  s_axi_awaddr_in,
   input  wire        s_axi_awvalid_in,
   output reg         s_axi_awready_out,
   input  wire [31:0] s_axi_wdata_in,
   input  wire [3:0]  s_axi_wstrb_in,
   input  wire        s_axi_wvalid_in,
   output reg         s_axi_wready_out,
   output reg  [1:0]  s_axi_bresp_out,
   output reg         s_axi_bvalid_out,
   input  wire        s_axi_bready_in,
   // AXI4-Lite read
   input  wire [7:0]  s_axi_araddr_in,
   input  wire        s_axi_arvalid_in,
   output reg         s_axi_arready_out,
   output reg  [31:0] s_axi_rdata_out,
   output reg  [1:0]  s_axi_rresp_out,
   output reg         s_axi_rvalid_out,
   input  wire        s_axi_rready_in,
   // Straps, from pins
   input  wire        strap_autox_in,
   input  wire        strap_led_mode_in,
   input  wire [4:0]  station_address_strap_in,
   // Link state, same clock
   input  wire [1:0]  local_advert_reg_in,
   input  wire [1:0]  partner_ability_reg_in,
   input  wire        an_full_duplex_in,
   input  wire        an_complete_in,
   input  wire        link_up_in,
   input  wire        speed_100_in,
   input  wire        pol_inverted_in,
   input  wire        phy_status_read_in,
   input  wire        link_activity_in,
   // Controls to the PHY core
   output reg         autox_en_out,
   output reg         force_cross_out,
   output reg         rx_pause_out,
   output reg         tx_pause_out,
   output reg         lower_thresh_out,
   output reg  [3:0]  squelch_out,
   output reg         nlp_disable_out,
   output reg         jabber_disable_out,
   output reg         phy_status_pol_out,
   output reg         link_led_output_out,
   output reg         irq_out
);
   localparam [31:0] STRETCH_FULL = `PGC_STRETCH_MS * `PGC_CLK_MHZ * 1000;
   localparam [23:0] STRETCH_CYC  = STRETCH_FULL[23:0];

   // Strap synchronisers
   reg        sa1_ff, sa2_ff, sl1_ff, sl2_ff;
   reg [4:0]  sp1_ff, sp2_ff;
   reg        strap_done_ff;
   wire       rst_any = !rst_n_in || soft_rst_in;

   always @(posedge clk_in) begin
      sa1_ff <= strap_autox_in;
      sa2_ff <= sa1_ff;
      sl1_ff <= strap_led_mode_in;
      sl2_ff <= sl1_ff;
      sp1_ff <= station_address_strap_in;
      sp2_ff <= sp1_ff;
   end

   // Register state
   reg        autox_ff, forcex_ff, ledbyp_ff, ledmode_ff;
   reg [4:0]  station_ff;
   reg        lowth_ff, nlpdis_ff, jabdis_ff, pol_ff;
   reg [3:0]  squelch_ff;
   reg [2:0]  irq_stat_ff, irq_mask_ff;
   reg        link_fd_prev_ff, pol_prev_ff;

   wire       rx_pause_w, tx_pause_w;
   pgc_pause_resolve u_pause (
      .local_adv_in   (local_advert_reg_in),
      .partner_adv_in (partner_ability_reg_in),
      .full_duplex_in (an_full_duplex_in),
      .rx_pause_out   (rx_pause_w),
      .tx_pause_out   (tx_pause_w)
   );

   wire link_fd100 = link_up_in && speed_100_in && an_full_duplex_in && an_complete_in;

   // Write channel: capture address and data independently
   reg        aw_have_ff, w_have_ff;
   reg [7:0]  aw_addr_ff;
   reg [31:0] w_data_ff;
   reg [3:0]  w_strb_ff;
   wire       wr_go = aw_have_ff && w_have_ff && !s_axi_bvalid_out;
   wire       wr_lo = w_strb_ff[0];
   wire       wr_hi = w_strb_ff[1];

   // Read channel
   wire       rd_go = s_axi_arvalid_in && s_axi_arready_out;
   reg [31:0] rd_word;
   reg        rd_ok;
   wire       rd_tenbase = rd_go && s_axi_araddr_in == `PGC_ADDR_TENBASE;
   wire       rd_irq     = rd_go && s_axi_araddr_in == `PGC_ADDR_IRQ_STAT;

   wire [2:0] ev;
   assign ev[0] = link_fd100 && !link_fd_prev_ff;
   assign ev[1] = !link_fd100 && link_fd_prev_ff;
   assign ev[2] = pol_inverted_in && !pol_prev_ff;

   always @* begin
      rd_ok = 1'b1;
      rd_word = 32'h0000_0000;
      case (s_axi_araddr_in)
         `PGC_ADDR_GENERAL: begin
            rd_word[`PGC_GC_AUTOX]     = autox_ff;
            rd_word[`PGC_GC_FORCEX]    = forcex_ff;
            rd_word[`PGC_GC_RXPAUSE]   = rx_pause_w;
            rd_word[`PGC_GC_TXPAUSE]   = tx_pause_w;
            rd_word[`PGC_GC_LINK100FD] = link_fd100;
            rd_word[`PGC_GC_LEDBYP]    = ledbyp_ff;
            rd_word[`PGC_GC_LEDMODE]   = ledmode_ff;
            rd_word[4:0]               = station_ff;
         end
         `PGC_ADDR_TENBASE: begin
            rd_word[`PGC_TB_LOWTH]                 = lowth_ff;
            rd_word[`PGC_TB_SQ_HI:`PGC_TB_SQ_LO]   = squelch_ff;
            rd_word[`PGC_TB_NLPDIS]                = nlpdis_ff;
            rd_word[`PGC_TB_POL]                   = pol_ff;
            rd_word[`PGC_TB_JABDIS]                = jabdis_ff;
         end
         `PGC_ADDR_IRQ_STAT:  rd_word[2:0] = irq_stat_ff;
         `PGC_ADDR_IRQ_MASK:  rd_word[2:0] = irq_mask_ff;
         `PGC_ADDR_LINK_STAT: rd_word[0]   = link_up_in;
         default:             rd_ok = 1'b0;
      endcase
   end

   always @(posedge clk_in) begin
      if (rst_any) begin
         strap_done_ff     <= 1'b0;
         autox_ff          <= 1'b1;
         forcex_ff         <= 1'b0;
         ledbyp_ff         <= 1'b0;
         ledmode_ff        <= 1'b0;
         station_ff        <= `PGC_STATION_NOM;
         lowth_ff          <= 1'b0;
         squelch_ff        <= `PGC_TB_SQ_RESET;
         nlpdis_ff         <= 1'b0;
         jabdis_ff         <= 1'b0;
         pol_ff            <= 1'b0;
         pol_prev_ff       <= 1'b0;
         link_fd_prev_ff   <= 1'b0;
         irq_stat_ff       <= 3'h0;
         irq_mask_ff       <= 3'h0;
         aw_have_ff        <= 1'b0;
         w_have_ff         <= 1'b0;
         aw_addr_ff        <= 8'h00;
         w_data_ff         <= 32'h0000_0000;
         w_strb_ff         <= 4'h0;
         s_axi_awready_out <= 1'b0;
         s_axi_wready_out  <= 1'b0;
         s_axi_bvalid_out  <= 1'b0;
         s_axi_bresp_out   <= `PGC_RESP_OKAY;
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out  <= 1'b0;
         s_axi_rresp_out   <= `PGC_RESP_OKAY;
         s_axi_rdata_out   <= 32'h0000_0000;
      end else begin
         // Straps caught once after release, past the synchroniser
         strap_done_ff <= 1'b1;
         if (!strap_done_ff) begin
            autox_ff   <= sa2_ff;
            ledmode_ff <= sl2_ff;
            station_ff <= sp2_ff;
         end
         link_fd_prev_ff <= link_fd100;
         pol_prev_ff     <= pol_inverted_in;

         // Write address and data accepted in either order
         s_axi_awready_out <= !aw_have_ff && !s_axi_awready_out;
         s_axi_wready_out  <= !w_have_ff && !s_axi_wready_out;
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_have_ff        <= 1'b1;
            aw_addr_ff        <= s_axi_awaddr_in;
            s_axi_awready_out <= 1'b0;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_have_ff        <= 1'b1;
            w_data_ff        <= s_axi_wdata_in;
            w_strb_ff        <= s_axi_wstrb_in;
            s_axi_wready_out <= 1'b0;
         end
         if (wr_go) begin
            aw_have_ff       <= 1'b0;
            w_have_ff        <= 1'b0;
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out  <= `PGC_RESP_OKAY;
            case (aw_addr_ff)
               `PGC_ADDR_GENERAL: begin
                  // Override holds until next reset
                  if (wr_hi) autox_ff  <= w_data_ff[`PGC_GC_AUTOX];
                  if (wr_hi) forcex_ff <= w_data_ff[`PGC_GC_FORCEX];
                  if (wr_lo) ledbyp_ff <= w_data_ff[`PGC_GC_LEDBYP];
                  if (wr_lo) ledmode_ff <= w_data_ff[`PGC_GC_LEDMODE];
               end
               `PGC_ADDR_TENBASE: begin
                  if (wr_hi) lowth_ff <= w_data_ff[`PGC_TB_LOWTH];
                  if (wr_hi && wr_lo)
                     squelch_ff <= w_data_ff[`PGC_TB_SQ_HI:`PGC_TB_SQ_LO];
                  if (wr_lo) nlpdis_ff <= w_data_ff[`PGC_TB_NLPDIS];
                  if (wr_lo) jabdis_ff <= w_data_ff[`PGC_TB_JABDIS];
               end
               `PGC_ADDR_IRQ_MASK: if (wr_lo) irq_mask_ff <= w_data_ff[2:0];
               `PGC_ADDR_IRQ_STAT: ;
               `PGC_ADDR_LINK_STAT: ;
               default: s_axi_bresp_out <= `PGC_RESP_SLVERR;
            endcase
         end
         if (s_axi_bvalid_out && s_axi_bready_in)
            s_axi_bvalid_out <= 1'b0;

         // Read: one in flight
         s_axi_arready_out <= !s_axi_rvalid_out && !s_axi_arready_out;
         if (rd_go) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b1;
            s_axi_rdata_out   <= rd_word;
            s_axi_rresp_out   <= rd_ok ? `PGC_RESP_OKAY : `PGC_RESP_SLVERR;
         end
         if (s_axi_rvalid_out && s_axi_rready_in)
            s_axi_rvalid_out <= 1'b0;

         // Polarity: tenbase read clears both copies; new event wins
         if (pol_inverted_in)
            pol_ff <= 1'b1;
         else if (rd_tenbase)
            pol_ff <= 1'b0;

         // Sticky status, read clears, set wins
         irq_stat_ff <= (rd_irq ? 3'h0 : irq_stat_ff) | ev;
      end
   end

   // LED stretching
   reg [23:0] stretch_cnt_ff;
   always @(posedge clk_in) begin
      if (rst_any)
         stretch_cnt_ff <= 24'h00_0000;
      else if (link_activity_in)
         stretch_cnt_ff <= STRETCH_CYC;
      else if (stretch_cnt_ff != 24'h00_0000)
         stretch_cnt_ff <= stretch_cnt_ff - 24'h00_0001;
   end
   wire act_seen  = ledbyp_ff ? link_activity_in : (stretch_cnt_ff != 24'h00_0000);
   wire blink_ph  = stretch_cnt_ff[20];
   wire led_act   = ledbyp_ff ? link_activity_in : (act_seen && blink_ph);

   // Registered outputs
   always @(posedge clk_in) begin
      if (rst_any) begin
         autox_en_out        <= 1'b0;
         force_cross_out     <= 1'b0;
         rx_pause_out        <= 1'b0;
         tx_pause_out        <= 1'b0;
         lower_thresh_out    <= 1'b0;
         squelch_out         <= 4'h0;
         nlp_disable_out     <= 1'b0;
         jabber_disable_out  <= 1'b0;
         phy_status_pol_out  <= 1'b0;
         link_led_output_out <= 1'b0;
         irq_out             <= 1'b0;
      end else begin
         autox_en_out        <= autox_ff;
         force_cross_out     <= forcex_ff;
         rx_pause_out        <= rx_pause_w;
         tx_pause_out        <= tx_pause_w;
         lower_thresh_out    <= lowth_ff;
         squelch_out         <= squelch_ff;
         nlp_disable_out     <= nlpdis_ff;
         jabber_disable_out  <= jabdis_ff && !speed_100_in;
         phy_status_pol_out  <= pol_ff;
         // Mode 1 steady link; mode 0 link with activity blink
         link_led_output_out <= link_up_in && !(!ledmode_ff && led_act);
         // Mask bit high lets its status bit raise the line
         irq_out             <= |(irq_stat_ff & irq_mask_ff);
      end
   end
endmodule

// file: logic/pgc_map.vh
// Notes on behaviour
// - Bit 15 enables automatic crossover; reset value from strap input.
// - Bit 14 forces pair crossover when set; resets to zero.
// - Bit 13 receive pause from advert bits 11:10, only when full duplex.
// - Bit 12 transmit pause from same advert bits, only when full duplex.
// - Bit 11 reads one only for active autonegotiated 100 full-duplex link.
// - Reserved bits ignore writes and read zero in both registers.
// - Bit 7 bypasses LED stretching so LED follows raw indication; resets zero.
// - Bits 4:0 read strapped station address; nominal default 00001.
// - Tenbase bit 13 selects lower receive threshold; resets zero.
// - Bits 12:9 set squelch, 50 mV steps from 200 mV; reset zero.
// - Tenbase bit 7 stops normal link pulses when set; resets zero.
// - Bit 4 inverted polarity, mirrors status bit 12; tenbase read clears both.
// - Tenbase bit 0 disables jabber protection, 10 Mb/s only.
`ifndef PGC_MAP_VH
`define PGC_MAP_VH
`define PGC_IDX_GENERAL    8'h19
`define PGC_IDX_TENBASE    8'h1A
`define PGC_ADDR_GENERAL   8'h64
`define PGC_ADDR_TENBASE   8'h68
`define PGC_ADDR_IRQ_STAT  8'h80
`define PGC_ADDR_IRQ_MASK  8'h84
`define PGC_ADDR_LINK_STAT 8'h88
`define PGC_GC_AUTOX       15
`define PGC_GC_FORCEX      14
`define PGC_GC_RXPAUSE     13
`define PGC_GC_TXPAUSE     12
`define PGC_GC_LINK100FD   11
`define PGC_GC_LEDBYP      7
`define PGC_GC_LEDMODE     5
`define PGC_TB_LOWTH       13
`define PGC_TB_SQ_HI       12
`define PGC_TB_SQ_LO       9
`define PGC_TB_NLPDIS      7
`define PGC_TB_POL         4
`define PGC_TB_JABDIS      0
`define PGC_TB_SQ_RESET    4'h0
`define PGC_STATION_NOM    5'h01
`define PGC_STRETCH_MS     50
`define PGC_CLK_MHZ        200
`define PGC_RESP_OKAY      2'h0
`define PGC_RESP_SLVERR    2'h2
`endif

// file: logic/pgc_pause_resolve.v
`timescale 1ns/1ps
module pgc_pause_resolve (
   // Advertised abilities, bit 1 asym, bit 0 sym
   input  wire [1:0] local_adv_in,
   input  wire [1:0] partner_adv_in,
   input  wire       full_duplex_in,
   // Resolution
   output reg        rx_pause_out,
   output reg        tx_pause_out
);
   always @* begin
      rx_pause_out = 1'b0;
      tx_pause_out = 1'b0;
      if (full_duplex_in) begin
         if (local_adv_in[0] && partner_adv_in[0]) begin
            rx_pause_out = 1'b1;
            tx_pause_out = 1'b1;
         end else if (local_adv_in == 2'h3 && partner_adv_in == 2'h2) begin
            rx_pause_out = 1'b1;
         end else if (local_adv_in == 2'h2 && partner_adv_in == 2'h3) begin
            tx_pause_out = 1'b1;
         end
      end
   end
endmodule

// file: verification/pgc_regs_checker.sv
`timescale 1ns/1ps
module pgc_regs_checker (
   // Clock and resets
   input wire        clk_in,
   input wire        rst_n_in,
   input wire        soft_rst_in,
   // Bus
   input wire        s_axi_awvalid_in,
   input wire        s_axi_awready_out,
   input wire        s_axi_wvalid_in,
   input wire        s_axi_wready_out,
   input wire        s_axi_bvalid_out,
   input wire        s_axi_bready_in,
   input wire [7:0]  s_axi_araddr_in,
   input wire        s_axi_arvalid_in,
   input wire        s_axi_arready_out,
   input wire [31:0] s_axi_rdata_out,
   input wire [1:0]  s_axi_rresp_out,
   input wire        s_axi_rvalid_out,
   input wire        s_axi_rready_in,
   // Link state and results
   input wire [1:0]  local_advert_reg_in,
   input wire [1:0]  partner_ability_reg_in,
   input wire        an_full_duplex_in,
   input wire        pol_inverted_in,
   input wire        rx_pause_out,
   input wire        tx_pause_out,
   input wire        phy_status_pol_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in || soft_rst_in);
   wire [1:0] la = local_advert_reg_in;
   wire [1:0] pa = partner_ability_reg_in;
   // Pause table, rx then tx
   wire [1:0] exp_pause = {2{an_full_duplex_in}} &
      {(la[0] & pa[0]) | (la[0] & la[1] & ~pa[0] & pa[1]),
       (la[0] & pa[0]) | (~la[0] & la[1] & pa[0] & pa[1])};
   wire       unmapped = !(s_axi_araddr_in inside {8'h64, 8'h68, 8'h80, 8'h84, 8'h88});
   sequence wr_taken;
      s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
   endsequence
   sequence rd_taken;
      s_axi_arvalid_in && s_axi_arready_out;
   endsequence
   wr_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid_out)
      else $error("write answer late");
   rd_answer_a: assert property (rd_taken |=> s_axi_rvalid_out)
      else $error("read answer late");
   b_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
      else $error("bvalid dropped early");
   r_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
      s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data not held");
   ar_refused_a: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
      else $error("read taken while answer pending");
   unmapped_rd_a: assert property (rd_taken ##0 unmapped |=>
      s_axi_rresp_out == 2'h2 && s_axi_rdata_out == 32'h0) else $error("unmapped read");
   gc_reserved_a: assert property (rd_taken ##0 s_axi_araddr_in == 8'h64 |=>
      (s_axi_rdata_out & 32'hFFFF0740) == 32'h0) else $error("general reserved bits set");
   tb_reserved_a: assert property (rd_taken ##0 s_axi_araddr_in == 8'h68 |=>
      (s_axi_rdata_out & 32'hFFFFC16E) == 32'h0) else $error("tenbase reserved bits set");
   pause_res_a: assert property (1'b1 |=> {rx_pause_out, tx_pause_out} == $past(exp_pause))
      else $error("pause resolution wrong");
   pol_set_a: assert property (pol_inverted_in |-> ##2 phy_status_pol_out)
      else $error("polarity copy not set");
endmodule

bind pgc_regs pgc_regs_checker u_chk (.*);

// file: verification/pgc_regs_tb_top.sv
`timescale 1ns/1ps
module pgc_regs_tb_top;
   reg         clk_in = 1'b0, rst_n_in = 1'b0, soft_rst_in = 1'b0;
   reg  [7:0]  s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
   reg  [31:0] s_axi_wdata_in = 32'h0;
   reg  [3:0]  s_axi_wstrb_in = 4'hF;
   reg         s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
   reg         s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
   reg         strap_autox_in = 1'b0, strap_led_mode_in = 1'b1;
   reg  [4:0]  station_address_strap_in = 5'h0B;
   reg  [1:0]  local_advert_reg_in = 2'h0, partner_ability_reg_in = 2'h0;
   reg         an_full_duplex_in = 1'b0, an_complete_in = 1'b0, link_up_in = 1'b0;
   reg         speed_100_in = 1'b0, pol_inverted_in = 1'b0, phy_status_read_in = 1'b0;
   reg         link_activity_in = 1'b0;
   wire        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
   wire        s_axi_rvalid_out, autox_en_out, force_cross_out, rx_pause_out, tx_pause_out;
   wire        lower_thresh_out, nlp_disable_out, jabber_disable_out, phy_status_pol_out;
   wire        link_led_output_out, irq_out;
   wire [1:0]  s_axi_bresp_out, s_axi_rresp_out;
   wire [31:0] s_axi_rdata_out;
   wire [3:0]  squelch_out;
   integer     n_errors = 0, checked = 0, i;
   reg  [31:0] rd_d;
   reg  [1:0]  rd_r;

   always #2.5 clk_in = ~clk_in;

   pgc_regs u_dut (.*);

   task cyc(input integer n);
      repeat (n) @(posedge clk_in);
   endtask

   task ck(input [8*8:1] nm, input [31:0] e, input [31:0] g);
      begin
         checked = checked + 1;
         if (g !== e) begin
            n_errors = n_errors + 1;
            $display("mismatch %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask

   // Master holds each channel until its own ready
   task wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge clk_in);
         s_axi_awaddr_in <= a;
         s_axi_awvalid_in <= 1'b1;
         s_axi_wdata_in <= d;
         s_axi_wvalid_in <= 1'b1;
         s_axi_bready_in <= 1'b1;
         do begin
            @(posedge clk_in);
            if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
         end while (!s_axi_bvalid_out);
         s_axi_bready_in <= 1'b0;
         rd_r = s_axi_bresp_out;
      end
   endtask

   task rd(input [7:0] a);
      begin
         @(posedge clk_in);
         s_axi_araddr_in <= a;
         s_axi_arvalid_in <= 1'b1;
         s_axi_rready_in <= 1'b1;
         do begin
            @(posedge clk_in);
            if (s_axi_arvalid_in && s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
         end while (!s_axi_rvalid_out);
         s_axi_rready_in <= 1'b0;
         rd_d = s_axi_rdata_out;
         rd_r = s_axi_rresp_out;
      end
   endtask

   task rck(input [7:0] a, input [31:0] e);
      begin
         rd(a);
         ck("rdata", e, rd_d);
      end
   endtask

   task pol_pulse;
      begin
         pol_inverted_in <= 1'b1;
         cyc(1);
         pol_inverted_in <= 1'b0;
         cyc(3);
      end
   endtask

   task test_done;
      begin
         if (n_errors == 0 && checked > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask

   initial begin
      cyc(20000);
      n_errors = n_errors + 1;
      test_done;
   end

   initial begin
      cyc(6);
      rst_n_in <= 1'b1;
      cyc(4);
      rd(8'h80);
      rck(8'h64, 32'h0000002B);
      rck(8'h68, 32'h00000000);
      wr(8'h64, 32'hFFFFFFFF);
      rck(8'h64, 32'h0000C0AB);
      ck("cross", 32'h3, {autox_en_out, force_cross_out});
      wr(8'h68, 32'hFFFFFFFF);
      rck(8'h68, 32'h00003E81);
      ck("squelch", 32'hF, squelch_out);
      ck("tenbase", 32'h7, {lower_thresh_out, nlp_disable_out, jabber_disable_out});
      speed_100_in <= 1'b1;
      cyc(3);
      ck("jabber", 32'h0, jabber_disable_out);
      wr(8'h68, 32'h0);
      cyc(2);
      ck("squelch", 32'h0, squelch_out);
      wr(8'h64, 32'h0);
      rck(8'h64, 32'h0000000B);
      ck("autox", 32'h0, autox_en_out);
      link_up_in <= 1'b1;
      an_complete_in <= 1'b1;
      an_full_duplex_in <= 1'b1;
      local_advert_reg_in <= 2'h1;
      partner_ability_reg_in <= 2'h1;
      cyc(3);
      rck(8'h64, 32'h0000380B);
      an_complete_in <= 1'b0;
      cyc(3);
      rck(8'h64, 32'h0000300B);
      for (i = 0; i < 16; i = i + 1) begin
         local_advert_reg_in <= i[1:0];
         partner_ability_reg_in <= i[3:2];
         cyc(2);
      end
      an_full_duplex_in <= 1'b0;
      cyc(3);
      ck("pause", 32'h0, {rx_pause_out, tx_pause_out});
      wr(8'h64, 32'h80);
      link_activity_in <= 1'b1;
      cyc(3);
      ck("led", 32'h0, link_led_output_out);
      link_activity_in <= 1'b0;
      cyc(3);
      ck("led", 32'h1, link_led_output_out);
      wr(8'h64, 32'h0);
      link_activity_in <= 1'b1;
      cyc(1);
      link_activity_in <= 1'b0;
      cyc(3);
      ck("led", 32'h0, link_led_output_out);
      wr(8'h64, 32'h20);
      cyc(2);
      ck("led", 32'h1, link_led_output_out);
      rd(8'h80);
      wr(8'h84, 32'h0);
      phy_status_read_in <= 1'b1;
      pol_pulse;
      phy_status_read_in <= 1'b0;
      ck("pol", 32'h1, phy_status_pol_out);
      ck("irq", 32'h0, irq_out);
      rck(8'h68, 32'h00000010);
      rck(8'h68, 32'h00000000);
      ck("pol", 32'h0, phy_status_pol_out);
      rck(8'h80, 32'h00000004);
      ck("irq", 32'h0, irq_out);
      wr(8'h84, 32'h4);
      pol_pulse;
      ck("irq", 32'h1, irq_out);
      rck(8'h80, 32'h00000004);
      cyc(2);
      ck("irq", 32'h0, irq_out);
      rd(8'h40);
      ck("rresp", 32'h2, rd_r);
      ck("rdata", 32'h0, rd_d);
      wr(8'h40, 32'h1);
      ck("bresp", 32'h2, rd_r);
      soft_rst_in <= 1'b1;
      cyc(1);
      soft_rst_in <= 1'b0;
      cyc(4);
      rck(8'h64, 32'h0000002B);
      test_done;
   end
endmodule
